// ### rtl/bbet_exec_timing.sv
/*
 * Execution timing sequencer for single-bit, bit-field and conditional
 * branch operations. Takes one decoded request at a time, holds BUSY for
 * exactly the table's total clock count and marks each operand read,
 * instruction prefetch and operand write bus cycle inside that count.
 * Assumes the decoder and bus interface run on CLK; address times that
 * other tables add are reported as a kind and left to the caller.
 */
// Behaviour
// - Bus cycles lie inside the total count.
// - Register single-bit ops take 1/4/5 clocks.
// - Memory bit test takes 4/4/5 clocks.
// - Memory bit modify takes 4/4/5, one write.
// - Memory bit ops add immediate or EA fetch.
// - Register field modify takes 9/12/12 clocks.
// - Narrow memory field modify takes 16, r1 w1.
// - Five-byte field modify takes 24, r2 w2.
// - Full-width field straddling five bytes reads twice.
// - Field test takes 3/6/7, 11/11/12, 15/15/16.
// - Field extract takes 5/8/8, 13, 18.
// - Field insert takes 7/10/10, 14/14/15, 20/20/21.
// - Find first one takes 15/18/18, 24, 32.
// - Memory field ops add immediate calculation time.
// - Branches are complete, no address time added.
// - Live decrement-and-branch takes 3/6/9 clocks.
// - Expired takes 7/10/10; true condition 3/6/7.
`timescale 1ns/10ps

module bbet_exec_timing
    import bbet_pkg::*;
#(
    parameter int ELAPSED_W = 6
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Request from the decoder
    input wire logic START,
    input wire bbet_req_t REQ,
    output logic READY,
    // Timing of the operation in progress
    output bbet_timing_t TIMING,
    output logic BUSY,
    output logic DONE,
    // Bus cycle marks
    output logic RD_STROBE,
    output logic PF_STROBE,
    output logic WR_STROBE
);

    if (ELAPSED_W < BBET_TOTAL_W)
    begin : g_width_check
        $error("ELAPSED_W too narrow for the longest total count");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } bbet_state_t;

    function automatic logic [ELAPSED_W-1:0] ext2(logic [1:0] c);
        return ELAPSED_W'(c);
    endfunction

    bbet_state_t state_q;
    bbet_state_t state_d;
    bbet_timing_t timing_d;
    bbet_timing_t timing_q;
    logic [ELAPSED_W-1:0] elapsed_q;
    logic [ELAPSED_W-1:0] total_e;
    logic accept;
    logic run;
    logic last;

    bbet_table u_table
    (
        .req(REQ),
        .timing(timing_d)
    );

    assign run = (state_q == ST_RUN);
    assign accept = START && (state_q == ST_IDLE);
    assign total_e = ELAPSED_W'(timing_q.total);
    // The operation ends on its last counted clock, bus cycles included.
    assign last = run && (elapsed_q == total_e - ext2(2'h1));

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: state_d = START ? ST_RUN : ST_IDLE;
            ST_RUN: state_d = last ? ST_IDLE : ST_RUN;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            timing_q <= '0;
        else if (accept)
            timing_q <= timing_d;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            elapsed_q <= '0;
        else if (accept)
            elapsed_q <= '0;
        else if (run)
            elapsed_q <= elapsed_q + ext2(2'h1);
    end

    // Reads come first, prefetches next, writes close the count; the table
    // guarantees they never overlap, so no arbitration is needed.
    assign RD_STROBE = run && (elapsed_q < ext2(timing_q.reads));
    assign PF_STROBE = run && (elapsed_q >= ext2(timing_q.reads))
        && (elapsed_q < ext2(timing_q.reads) + ext2(timing_q.prefetches));
    assign WR_STROBE = run && (elapsed_q >= total_e - ext2(timing_q.writes));
    assign READY = (state_q == ST_IDLE);
    assign BUSY = run;
    assign DONE = last;
    assign TIMING = timing_q;

    // Checking helpers: the accepted request and per-operation cycle tallies.
    bbet_req_t req_q;
    logic took_q;
    logic [ELAPSED_W-1:0] run_len_q;
    logic [2:0] rd_cnt_q;
    logic [2:0] pf_cnt_q;
    logic [2:0] wr_cnt_q;

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            req_q <= '0;
            took_q <= 1'b0;
            run_len_q <= '0;
            rd_cnt_q <= 3'h0;
            pf_cnt_q <= 3'h0;
            wr_cnt_q <= 3'h0;
        end
        else
        begin
            took_q <= accept;
            if (accept)
            begin
                req_q <= REQ;
                run_len_q <= '0;
                rd_cnt_q <= 3'h0;
                pf_cnt_q <= 3'h0;
                wr_cnt_q <= 3'h0;
            end
            else if (run)
            begin
                run_len_q <= run_len_q + ext2(2'h1);
                rd_cnt_q <= rd_cnt_q + {2'h0, RD_STROBE};
                pf_cnt_q <= pf_cnt_q + {2'h0, PF_STROBE};
                wr_cnt_q <= wr_cnt_q + {2'h0, WR_STROBE};
            end
        end
    end

    function automatic logic [5:0] pick(bbet_src_t s, logic [5:0] b, logic [5:0] c,
        logic [5:0] w);
        return (s == BBET_SRC_PIPE) ? b : ((s == BBET_SRC_CACHE) ? c : w);
    endfunction

    logic is_sb;
    logic is_sb_mod;
    logic is_field;
    logic is_fmod;
    logic q_wide;
    logic q_ext;

    assign is_sb = (req_q.op <= BBET_OP_SINGLE_BIT_SET);
    assign is_sb_mod = is_sb && (req_q.op != BBET_OP_SINGLE_BIT_TEST);
    assign is_field = !is_sb && (req_q.op <= BBET_OP_FIELD_FIND_FIRST_ONE);
    assign is_fmod = (req_q.op == BBET_OP_FIELD_TOGGLE) || (req_q.op == BBET_OP_FIELD_CLEAR)
        || (req_q.op == BBET_OP_FIELD_SET);
    assign q_wide = bbet_field_wide(req_q.field_off_lo, req_q.field_width);
    assign q_ext = (req_q.fetch_src == BBET_SRC_EXTERNAL);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence s_wide_rmw;
        RD_STROBE [*2] ##21 WR_STROBE ##1 (WR_STROBE && DONE);
    endsequence

    sequence s_single_mark_then_done(logic mark);
        (BUSY && !DONE) [*4] ##1 (DONE && mark);
    endsequence

    property p_bus_in_total;
        DONE |-> (rd_cnt_q + {2'h0, RD_STROBE} == {1'b0, TIMING.reads})
            && (pf_cnt_q + {2'h0, PF_STROBE} == {1'b0, TIMING.prefetches})
            && (wr_cnt_q + {2'h0, WR_STROBE} == {1'b0, TIMING.writes});
    endproperty
    a_bus_in_total: assert property (p_bus_in_total)
        else $error("bus cycle tally differs from reported counts");

    property p_run_len;
        DONE |-> (run_len_q == total_e - ext2(2'h1)) ##1 (READY && !BUSY);
    endproperty
    a_run_len: assert property (p_run_len)
        else $error("busy time differs from total count");

    property p_sb_reg;
        took_q && is_sb && !req_q.mem_operand |->
            TIMING.total == pick(req_q.fetch_src, 6'h01, 6'h04, 6'h05)
            && TIMING.prefetches == {1'b0, q_ext} && TIMING.writes == 2'h0;
    endproperty
    a_sb_reg: assert property (p_sb_reg)
        else $error("register single-bit timing wrong");

    property p_sb_test_mem;
        accept && REQ.op == BBET_OP_SINGLE_BIT_TEST && REQ.mem_operand
            && REQ.fetch_src == BBET_SRC_EXTERNAL |=> s_single_mark_then_done(!WR_STROBE)
            and (PF_STROBE ##1 !PF_STROBE);
    endproperty
    a_sb_test_mem: assert property (p_sb_test_mem)
        else $error("memory bit test worst case wrong");

    property p_sb_mod_mem;
        took_q && is_sb_mod && req_q.mem_operand |->
            TIMING.total == pick(req_q.fetch_src, 6'h04, 6'h04, 6'h05)
            && TIMING.writes == 2'h1 && TIMING.reads == 2'h0;
    endproperty
    a_sb_mod_mem: assert property (p_sb_mod_mem)
        else $error("memory bit modify timing wrong");

    property p_sb_addr;
        accept && REQ.op <= BBET_OP_SINGLE_BIT_SET && REQ.mem_operand |=>
            TIMING.addr_add == ($past(REQ.bitnum_imm) ? BBET_ADD_FETCH_IMM : BBET_ADD_FETCH_EA);
    endproperty
    a_sb_addr: assert property (p_sb_addr)
        else $error("single-bit address time kind wrong");

    property p_fmod_reg;
        took_q && is_fmod && !req_q.mem_operand |->
            TIMING.total == pick(req_q.fetch_src, 6'h09, 6'h0c, 6'h0c) && TIMING.reads == 2'h0;
    endproperty
    a_fmod_reg: assert property (p_fmod_reg)
        else $error("register field modify timing wrong");

    property p_fmod_narrow;
        took_q && is_fmod && req_q.mem_operand && !q_wide |->
            TIMING.total == 6'h10 && TIMING.reads == 2'h1 && TIMING.writes == 2'h1
            && TIMING.prefetches == {1'b0, q_ext};
    endproperty
    a_fmod_narrow: assert property (p_fmod_narrow)
        else $error("narrow memory field modify timing wrong");

    property p_fmod_wide;
        accept && REQ.mem_operand && bbet_field_wide(REQ.field_off_lo, REQ.field_width)
            && REQ.fetch_src == BBET_SRC_PIPE
            && (REQ.op == BBET_OP_FIELD_TOGGLE || REQ.op == BBET_OP_FIELD_CLEAR
            || REQ.op == BBET_OP_FIELD_SET) |=> s_wide_rmw;
    endproperty
    a_fmod_wide: assert property (p_fmod_wide)
        else $error("five-byte field modify sequence wrong");

    property p_full_width;
        took_q && is_field && req_q.mem_operand && req_q.field_width == BBET_WIDTH_MAX_CODE |->
            TIMING.reads == ((req_q.field_off_lo == 3'h0) ? 2'h1 : 2'h2);
    endproperty
    a_full_width: assert property (p_full_width)
        else $error("full-width field operand cycle count wrong");

    property p_ftest;
        took_q && req_q.op == BBET_OP_FIELD_TEST |-> TIMING.total ==
            (!req_q.mem_operand ? pick(req_q.fetch_src, 6'h03, 6'h06, 6'h07)
            : (q_wide ? pick(req_q.fetch_src, 6'h0f, 6'h0f, 6'h10)
            : pick(req_q.fetch_src, 6'h0b, 6'h0b, 6'h0c)));
    endproperty
    a_ftest: assert property (p_ftest)
        else $error("field test timing wrong");

    property p_fext;
        took_q && (req_q.op == BBET_OP_FIELD_EXTRACT_SIGNED
            || req_q.op == BBET_OP_FIELD_EXTRACT_UNSIGNED) |-> TIMING.total ==
            (!req_q.mem_operand ? pick(req_q.fetch_src, 6'h05, 6'h08, 6'h08)
            : (q_wide ? 6'h12 : 6'h0d)) && TIMING.writes == 2'h0;
    endproperty
    a_fext: assert property (p_fext)
        else $error("field extract timing wrong");

    property p_fins;
        took_q && req_q.op == BBET_OP_FIELD_INSERT |-> TIMING.total ==
            (!req_q.mem_operand ? pick(req_q.fetch_src, 6'h07, 6'h0a, 6'h0a)
            : (q_wide ? pick(req_q.fetch_src, 6'h14, 6'h14, 6'h15)
            : pick(req_q.fetch_src, 6'h0e, 6'h0e, 6'h0f)));
    endproperty
    a_fins: assert property (p_fins)
        else $error("field insert timing wrong");

    property p_fffo;
        took_q && req_q.op == BBET_OP_FIELD_FIND_FIRST_ONE |-> TIMING.total ==
            (!req_q.mem_operand ? pick(req_q.fetch_src, 6'h0f, 6'h12, 6'h12)
            : (q_wide ? 6'h20 : 6'h18));
    endproperty
    a_fffo: assert property (p_fffo)
        else $error("find first one timing wrong");

    property p_field_addr;
        took_q && is_field |->
            TIMING.addr_add == (req_q.mem_operand ? BBET_ADD_CALC_IMM : BBET_ADD_NONE);
    endproperty
    a_field_addr: assert property (p_field_addr)
        else $error("field address time kind wrong");

    property p_branch;
        took_q && req_q.op >= BBET_OP_BRANCH_TAKEN && req_q.op <= BBET_OP_BRANCH_NOT_TAKEN_LONG
            |-> TIMING.addr_add == BBET_ADD_NONE && TIMING.total ==
            ((req_q.op == BBET_OP_BRANCH_NOT_TAKEN_BYTE)
            ? pick(req_q.fetch_src, 6'h01, 6'h04, 6'h05)
            : (req_q.op == BBET_OP_BRANCH_NOT_TAKEN_WORD)
            ? pick(req_q.fetch_src, 6'h03, 6'h06, 6'h07)
            : pick(req_q.fetch_src, 6'h03, 6'h06, 6'h09));
    endproperty
    a_branch: assert property (p_branch)
        else $error("conditional branch timing wrong");

    property p_db_live;
        took_q && req_q.op == BBET_OP_DECREMENT_AND_BRANCH_LIVE |->
            TIMING.total == pick(req_q.fetch_src, 6'h03, 6'h06, 6'h09)
            && TIMING.prefetches == (q_ext ? 2'h2 : 2'h0);
    endproperty
    a_db_live: assert property (p_db_live)
        else $error("live decrement-and-branch timing wrong");

    property p_db_other;
        took_q && (req_q.op == BBET_OP_DECREMENT_AND_BRANCH_EXPIRED
            || req_q.op == BBET_OP_DECREMENT_AND_BRANCH_TRUE) |-> TIMING.total ==
            ((req_q.op == BBET_OP_DECREMENT_AND_BRANCH_TRUE)
            ? pick(req_q.fetch_src, 6'h03, 6'h06, 6'h07)
            : pick(req_q.fetch_src, 6'h07, 6'h0a, 6'h0a))
            && (!q_ext || req_q.op == BBET_OP_DECREMENT_AND_BRANCH_TRUE
            || TIMING.prefetches == 2'h3);
    endproperty
    a_db_other: assert property (p_db_other)
        else $error("expired or true decrement-and-branch timing wrong");

    property p_case_select;
        accept |=> (TIMING.prefetches != 2'h0) == ($past(REQ.fetch_src) == BBET_SRC_EXTERNAL);
    endproperty
    a_case_select: assert property (p_case_select)
        else $error("timing case does not follow fetch source");

endmodule

// ### rtl/bbet_pkg.sv
/*
 * Shared types and constants of the bit-operation and branch execution
 * timing sequencer: operation codes, request and result carriers, and the
 * timing table with best, cache and worst case clock counts.
 * Assumes a single processor clock; address calculation times from other
 * tables are reported as a kind only and are never added here.
 */
package bbet_pkg;

    localparam int BBET_TOTAL_W = 6;
    localparam int BBET_ROW_COUNT = 25;
    localparam logic [5:0] BBET_FIELD_MAX = 6'h20;
    localparam logic [4:0] BBET_WIDTH_MAX_CODE = 5'h00;

    typedef enum logic [4:0] {
        BBET_OP_SINGLE_BIT_TEST, BBET_OP_SINGLE_BIT_TOGGLE, BBET_OP_SINGLE_BIT_CLEAR,
        BBET_OP_SINGLE_BIT_SET, BBET_OP_FIELD_TEST, BBET_OP_FIELD_TOGGLE,
        BBET_OP_FIELD_CLEAR, BBET_OP_FIELD_SET, BBET_OP_FIELD_EXTRACT_SIGNED,
        BBET_OP_FIELD_EXTRACT_UNSIGNED, BBET_OP_FIELD_INSERT, BBET_OP_FIELD_FIND_FIRST_ONE,
        BBET_OP_BRANCH_TAKEN, BBET_OP_BRANCH_NOT_TAKEN_BYTE, BBET_OP_BRANCH_NOT_TAKEN_WORD,
        BBET_OP_BRANCH_NOT_TAKEN_LONG, BBET_OP_DECREMENT_AND_BRANCH_LIVE,
        BBET_OP_DECREMENT_AND_BRANCH_EXPIRED, BBET_OP_DECREMENT_AND_BRANCH_TRUE
    } bbet_op_t;

    // Where the instruction words come from selects the timing case.
    typedef enum logic [1:0] {
        BBET_SRC_PIPE = 2'h0,
        BBET_SRC_CACHE = 2'h1,
        BBET_SRC_EXTERNAL = 2'h2
    } bbet_src_t;

    typedef enum logic [1:0] {
        BBET_ADD_NONE = 2'h0,
        BBET_ADD_FETCH_EA = 2'h1,
        BBET_ADD_FETCH_IMM = 2'h2,
        BBET_ADD_CALC_IMM = 2'h3
    } bbet_add_t;

    typedef enum logic [4:0] {
        BBET_ROW_SB_REG, BBET_ROW_SB_TEST_MEM, BBET_ROW_SB_MOD_MEM,
        BBET_ROW_F_TEST_REG, BBET_ROW_F_TEST_NARROW, BBET_ROW_F_TEST_WIDE,
        BBET_ROW_F_MOD_REG, BBET_ROW_F_MOD_NARROW, BBET_ROW_F_MOD_WIDE,
        BBET_ROW_F_EXT_REG, BBET_ROW_F_EXT_NARROW, BBET_ROW_F_EXT_WIDE,
        BBET_ROW_F_INS_REG, BBET_ROW_F_INS_NARROW, BBET_ROW_F_INS_WIDE,
        BBET_ROW_F_FFO_REG, BBET_ROW_F_FFO_NARROW, BBET_ROW_F_FFO_WIDE,
        BBET_ROW_BR_TAKEN, BBET_ROW_BR_NT_BYTE, BBET_ROW_BR_NT_WORD, BBET_ROW_BR_NT_LONG,
        BBET_ROW_DB_LIVE, BBET_ROW_DB_EXPIRED, BBET_ROW_DB_TRUE
    } bbet_row_idx_t;

    typedef struct packed {
        bbet_op_t op;
        logic mem_operand;
        logic bitnum_imm;
        bbet_src_t fetch_src;
        logic [2:0] field_off_lo;
        logic [4:0] field_width;
    } bbet_req_t;

    typedef struct packed {
        logic [5:0] total;
        logic [1:0] reads;
        logic [1:0] prefetches;
        logic [1:0] writes;
        bbet_add_t addr_add;
    } bbet_timing_t;

    typedef struct packed {
        logic [5:0] best;
        logic [5:0] cache;
        logic [5:0] worst;
        logic [1:0] reads;
        logic [1:0] writes;
        logic [1:0] worst_pf;
    } bbet_row_t;

    // Columns: best, cache, worst, operand reads, operand writes, worst prefetches.
    localparam bbet_row_t BBET_ROWS [0:BBET_ROW_COUNT-1] = '{
        '{6'h01, 6'h04, 6'h05, 2'h0, 2'h0, 2'h1},
        '{6'h04, 6'h04, 6'h05, 2'h0, 2'h0, 2'h1},
        '{6'h04, 6'h04, 6'h05, 2'h0, 2'h1, 2'h1},
        '{6'h03, 6'h06, 6'h07, 2'h0, 2'h0, 2'h1},
        '{6'h0b, 6'h0b, 6'h0c, 2'h1, 2'h0, 2'h1},
        '{6'h0f, 6'h0f, 6'h10, 2'h2, 2'h0, 2'h1},
        '{6'h09, 6'h0c, 6'h0c, 2'h0, 2'h0, 2'h1},
        '{6'h10, 6'h10, 6'h10, 2'h1, 2'h1, 2'h1},
        '{6'h18, 6'h18, 6'h18, 2'h2, 2'h2, 2'h1},
        '{6'h05, 6'h08, 6'h08, 2'h0, 2'h0, 2'h1},
        '{6'h0d, 6'h0d, 6'h0d, 2'h1, 2'h0, 2'h1},
        '{6'h12, 6'h12, 6'h12, 2'h2, 2'h0, 2'h1},
        '{6'h07, 6'h0a, 6'h0a, 2'h0, 2'h0, 2'h1},
        '{6'h0e, 6'h0e, 6'h0f, 2'h1, 2'h1, 2'h1},
        '{6'h14, 6'h14, 6'h15, 2'h2, 2'h2, 2'h1},
        '{6'h0f, 6'h12, 6'h12, 2'h0, 2'h0, 2'h1},
        '{6'h18, 6'h18, 6'h18, 2'h1, 2'h0, 2'h1},
        '{6'h20, 6'h20, 6'h20, 2'h2, 2'h0, 2'h1},
        '{6'h03, 6'h06, 6'h09, 2'h0, 2'h0, 2'h2},
        '{6'h01, 6'h04, 6'h05, 2'h0, 2'h0, 2'h1},
        '{6'h03, 6'h06, 6'h07, 2'h0, 2'h0, 2'h1},
        '{6'h03, 6'h06, 6'h09, 2'h0, 2'h0, 2'h2},
        '{6'h03, 6'h06, 6'h09, 2'h0, 2'h0, 2'h2},
        '{6'h07, 6'h0a, 6'h0a, 2'h0, 2'h0, 2'h3},
        '{6'h03, 6'h06, 6'h07, 2'h0, 2'h0, 2'h1}
    };

    // A field needs five bytes, and so two operand cycles, when it runs past 32 bits.
    function automatic logic bbet_field_wide(logic [2:0] off_lo, logic [4:0] width);
        logic [5:0] w;
        w = (width == BBET_WIDTH_MAX_CODE) ? BBET_FIELD_MAX : {1'b0, width};
        return (({3'h0, off_lo} + w) > BBET_FIELD_MAX);
    endfunction

endpackage

// ### rtl/bbet_table.sv
/*
 * Timing table lookup: turns a decoded request into the total clock count,
 * the operand read, prefetch and write counts and the address time to add.
 * Purely combinational; the request comes from logic on the same clock.
 */
`timescale 1ns/10ps

module bbet_table
    import bbet_pkg::*;
(
    // Decoded request
    input wire bbet_req_t req,
    // Looked-up timing
    output bbet_timing_t timing
);

    function automatic bbet_row_idx_t row_of(bbet_req_t r);
        logic wide;
        bbet_row_idx_t base;
        wide = bbet_field_wide(r.field_off_lo, r.field_width);
        base = BBET_ROW_SB_REG;
        unique case (r.op)
            BBET_OP_SINGLE_BIT_TEST:
                return r.mem_operand ? BBET_ROW_SB_TEST_MEM : BBET_ROW_SB_REG;
            BBET_OP_SINGLE_BIT_TOGGLE, BBET_OP_SINGLE_BIT_CLEAR, BBET_OP_SINGLE_BIT_SET:
                return r.mem_operand ? BBET_ROW_SB_MOD_MEM : BBET_ROW_SB_REG;
            BBET_OP_FIELD_TEST: base = BBET_ROW_F_TEST_REG;
            BBET_OP_FIELD_TOGGLE, BBET_OP_FIELD_CLEAR, BBET_OP_FIELD_SET:
                base = BBET_ROW_F_MOD_REG;
            BBET_OP_FIELD_EXTRACT_SIGNED, BBET_OP_FIELD_EXTRACT_UNSIGNED:
                base = BBET_ROW_F_EXT_REG;
            BBET_OP_FIELD_INSERT: base = BBET_ROW_F_INS_REG;
            BBET_OP_FIELD_FIND_FIRST_ONE: base = BBET_ROW_F_FFO_REG;
            BBET_OP_BRANCH_TAKEN: return BBET_ROW_BR_TAKEN;
            BBET_OP_BRANCH_NOT_TAKEN_BYTE: return BBET_ROW_BR_NT_BYTE;
            BBET_OP_BRANCH_NOT_TAKEN_WORD: return BBET_ROW_BR_NT_WORD;
            BBET_OP_BRANCH_NOT_TAKEN_LONG: return BBET_ROW_BR_NT_LONG;
            BBET_OP_DECREMENT_AND_BRANCH_LIVE: return BBET_ROW_DB_LIVE;
            BBET_OP_DECREMENT_AND_BRANCH_EXPIRED: return BBET_ROW_DB_EXPIRED;
            BBET_OP_DECREMENT_AND_BRANCH_TRUE: return BBET_ROW_DB_TRUE;
            default: return BBET_ROW_SB_REG;
        endcase
        // Field rows come in register, narrow and wide triples.
        if (!r.mem_operand)
        begin
            return base;
        end
        return bbet_row_idx_t'(base + (wide ? 5'h02 : 5'h01));
    endfunction

    bbet_row_t row;

    always_comb
    begin
        row = BBET_ROWS[row_of(req)];
        timing.reads = row.reads;
        timing.writes = row.writes;
        unique case (req.fetch_src)
            BBET_SRC_PIPE:
            begin
                timing.total = row.best;
                timing.prefetches = 2'h0;
            end
            BBET_SRC_CACHE:
            begin
                timing.total = row.cache;
                timing.prefetches = 2'h0;
            end
            default:
            begin
                timing.total = row.worst;
                timing.prefetches = row.worst_pf;
            end
        endcase
        timing.addr_add = BBET_ADD_NONE;
        if (req.mem_operand && req.op <= BBET_OP_SINGLE_BIT_SET)
        begin
            timing.addr_add = req.bitnum_imm ? BBET_ADD_FETCH_IMM : BBET_ADD_FETCH_EA;
        end
        else if (req.mem_operand && req.op <= BBET_OP_FIELD_FIND_FIRST_ONE)
        begin
            timing.addr_add = BBET_ADD_CALC_IMM;
        end
    end

endmodule

// ### tb/bbet_mem_model.sv
/* Memory side model: tallies operand reads, prefetches and writes of one operation.
   Assumes the strobes are sampled on the rising clock edge. */
`timescale 1ns/10ps
module bbet_mem_model (
    // Clock, reset and take
    input wire logic clk,
    input wire logic reset,
    input wire logic take,
    // Bus cycle marks and tallies {reads, prefetches, writes}
    input wire logic rd,
    input wire logic pf,
    input wire logic wr,
    output logic [8:0] cnt
);
    // Tallies restart at each take, so only cycles inside one total are counted.
    always_ff @(posedge clk or posedge reset)
        if (reset)
            cnt <= 9'h000;
        else if (take)
            cnt <= 9'h000;
        else
            cnt <= cnt + {2'h0, rd, 2'h0, pf, 2'h0, wr};
endmodule

// ### tb/testbench.sv
/* Self-checking bench of the timing sequencer: table rows in all fetch cases, except the wide find first one row, run in the pipe case only.
   Assumes one clock and the memory side model. */
`timescale 1ns/10ps
module testbench;
    import bbet_pkg::*;
    logic clk, reset, start, ready, busy, done, rd, pf, wr, poke;
    bbet_req_t req;
    bbet_timing_t tim;
    logic [8:0] cnt;
    int n_mismatch, checks_done;
    bbet_exec_timing uut (.CLK(clk), .RESET(reset), .START(start), .REQ(req), .READY(ready),
        .TIMING(tim), .BUSY(busy), .DONE(done), .RD_STROBE(rd), .PF_STROBE(pf), .WR_STROBE(wr));
    bbet_mem_model mem (.clk(clk), .reset(reset), .take(start && ready), .rd(rd), .pf(pf),
        .wr(wr), .cnt(cnt));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
            $display("BAD %0t got %h exp %h", $time, got, exp);
        if (got !== exp)
            n_mismatch++;
    endtask
    task automatic run(input bbet_op_t op, input logic m, input bbet_src_t s,
        input logic [8:0] f, input logic [5:0] t, input logic [1:0] r, p, w, input bbet_add_t a);
        int k;
        int d;
        req = '{op, m, f[8], s, f[7:5], f[4:0]};
        start = 1;
        @(posedge clk);
        #1 start = 0;
        k = 0;
        d = 0;
        while (busy === 1'b1 && k < 40)
        begin
            k++;
            if (done === 1'b1)
                d = k;
            // A request made while busy must be ignored.
            start = poke && k == 2;
            @(posedge clk);
            #1;
        end
        start = 0;
        chk(k, t);
        chk(d, t);
        chk(tim, {t, r, p, w, a});
        chk(cnt, {1'b0, r, 1'b0, p, 1'b0, w});
        chk(ready, 1);
        @(posedge clk);
        #1;
    endtask
    task automatic tri3(input bbet_op_t op, input logic m, input logic [8:0] f,
        input logic [5:0] b, c, x, input logic [1:0] r, w, p, input bbet_add_t a);
        run(op, m, BBET_SRC_PIPE, f, b, r, 2'h0, w, a);
        run(op, m, BBET_SRC_CACHE, f, c, r, 2'h0, w, a);
        run(op, m, BBET_SRC_EXTERNAL, f, x, r, p, w, a);
    endtask
    task automatic t_single;
        for (int i = 0; i < 4; i++)
            tri3(bbet_op_t'(i), 0, 9'h100, 1, 4, 5, 0, 0, 1, BBET_ADD_NONE);
        tri3(BBET_OP_SINGLE_BIT_TEST, 1, 9'h100, 4, 4, 5, 0, 0, 1, BBET_ADD_FETCH_IMM);
        tri3(BBET_OP_SINGLE_BIT_TEST, 1, 9'h000, 4, 4, 5, 0, 0, 1, BBET_ADD_FETCH_EA);
        for (int i = 1; i < 4; i++)
            tri3(bbet_op_t'(i), 1, 9'h000, 4, 4, 5, 0, 1, 1, BBET_ADD_FETCH_EA);
        $display("single bit test done");
    endtask
    task automatic t_field;
        tri3(BBET_OP_FIELD_CLEAR, 0, 9'h008, 9, 12, 12, 0, 0, 1, BBET_ADD_NONE);
        tri3(BBET_OP_FIELD_SET, 1, 9'h008, 16, 16, 16, 1, 1, 1, BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_TOGGLE, 1, 9'h020, 24, 24, 24, 2, 2, 1, BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_TOGGLE, 1, 9'h000, 16, 16, 16, 1, 1, 1, BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_TEST, 1, 9'h0fa, 15, 15, 16, 2, 0, 1, BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_TEST, 0, 9'h008, 3, 6, 7, 0, 0, 1, BBET_ADD_NONE);
        tri3(BBET_OP_FIELD_TEST, 1, 9'h008, 11, 11, 12, 1, 0, 1, BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_EXTRACT_SIGNED, 0, 9'h008, 5, 8, 8, 0, 0, 1, BBET_ADD_NONE);
        tri3(BBET_OP_FIELD_EXTRACT_UNSIGNED, 1, 9'h0f9, 13, 13, 13, 1, 0, 1,
            BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_EXTRACT_SIGNED, 1, 9'h05f, 18, 18, 18, 2, 0, 1,
            BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_INSERT, 1, 9'h05f, 20, 20, 21, 2, 2, 1, BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_INSERT, 0, 9'h008, 7, 10, 10, 0, 0, 1, BBET_ADD_NONE);
        tri3(BBET_OP_FIELD_INSERT, 1, 9'h008, 14, 14, 15, 1, 1, 1, BBET_ADD_CALC_IMM);
        tri3(BBET_OP_FIELD_FIND_FIRST_ONE, 0, 9'h008, 15, 18, 18, 0, 0, 1, BBET_ADD_NONE);
        tri3(BBET_OP_FIELD_FIND_FIRST_ONE, 1, 9'h008, 24, 24, 24, 1, 0, 1,
            BBET_ADD_CALC_IMM);
        poke = 1;
        run(BBET_OP_FIELD_FIND_FIRST_ONE, 1, BBET_SRC_PIPE, 9'h05f, 32, 2, 0, 0,
            BBET_ADD_CALC_IMM);
        poke = 0;
        $display("bit field test done");
    endtask
    task automatic t_branch;
        logic [5:0] b [7] = '{3, 1, 3, 3, 3, 7, 3};
        logic [5:0] c [7] = '{6, 4, 6, 6, 6, 10, 6};
        logic [5:0] x [7] = '{9, 5, 7, 9, 9, 10, 7};
        logic [1:0] p [7] = '{2, 1, 1, 2, 2, 3, 1};
        for (int i = 0; i < 7; i++)
            tri3(bbet_op_t'(12 + i), 0, 9'h000, b[i], c[i], x[i], 0, 0, p[i],
                BBET_ADD_NONE);
        $display("branch test done");
    endtask
    task automatic conclude;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        n_mismatch = 0;
        checks_done = 0;
        reset = 1;
        start = 0;
        poke = 0;
        req = '0;
        repeat (12) @(posedge clk);
        #1 reset = 0;
        t_single();
        t_field();
        t_branch();
        conclude();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule
